// ===== shared/pcs_aux_pkg.sv
/*
 * Constants for the coding-sublayer auxiliary control block: register
 * offsets, field positions, reset values and code groups.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package pcs_aux_pkg;
    localparam logic [7:0] sd_cfg_addr      = 8'h00;
    localparam logic [7:0] lb_cfg_addr      = 8'h04;
    localparam logic [7:0] tstpat_cfg_addr  = 8'h08;
    localparam logic [7:0] tstpat_stat_addr = 8'h0c;
    localparam logic [7:0] lpi_cfg_addr     = 8'h10;
    localparam logic [7:0] lpi_stat_addr    = 8'h14;
    localparam logic [7:0] wake_cnt_addr    = 8'h18;
    localparam logic [7:0] link_stat_addr   = 8'h1c;
    localparam logic [7:0] fx_cfg_addr      = 8'h20;
    localparam logic [7:0] fx_stat_addr     = 8'h24;
    // Configuration field positions; bits 0 to 2 shared by gigabit and fiber config, the rest fiber only
    localparam int los_react_enable_bit   = 0;
    localparam int sigdet_polarity_bit   = 1;
    localparam int sigdet_source_select_bit   = 2;
    localparam int fx_ena_bit   = 4;
    localparam int fef_gen_bit  = 5;
    localparam int fef_chk_bit  = 6;
    localparam int unidir_bit   = 7;
    // Status field positions
    localparam int st_sigdet_bit = 0;
    localparam int st_sync_bit   = 1;
    localparam int st_synclost_bit = 2;
    localparam int st_fef_bit    = 3;
    localparam int rx_mode_bit   = 0;
    localparam int rx_quiet_bit  = 1;
    localparam int tx_mode_bit   = 2;
    localparam int tx_quiet_bit  = 3;
    localparam int rx_seen_bit   = 4;
    localparam int tx_seen_bit   = 5;
    localparam int pat_err_bit   = 0;
    localparam int pat_lock_bit  = 1;
    localparam logic [2:0] jtp_off = 3'h0;
    localparam logic [2:0] jtp_high = 3'h1;
    localparam logic [2:0] jtp_low = 3'h2;
    localparam logic [2:0] jtp_mixed = 3'h3;
    localparam logic [2:0] jtp_crpat_long = 3'h4;
    localparam logic [2:0] jtp_crpat_short = 3'h5;
    // Reset values
    localparam logic [7:0] sd_cfg_reset = 8'h00;
    localparam logic [7:0] fx_cfg_reset = 8'h00;
    // Code groups (10-bit, gigabit side)
    localparam logic [9:0] k28_5_code = 10'h0fa;
    localparam logic [9:0] lpi_code   = 10'h1c7;
    localparam logic [9:0] idle_code  = 10'h283;
    localparam logic [9:0] hf_code    = 10'h2aa;
    localparam logic [9:0] lf_code    = 10'h3e0;
    localparam logic [9:0] mf_code    = 10'h333;
    localparam logic [9:0] fef_code   = 10'h3f0;
    // Low power idle timing, counted in core clock cycles
    localparam logic [15:0] lpi_sleep_cycles = 16'h0040;
    localparam logic [15:0] lpi_quiet_cycles = 16'h0800;
    localparam logic [15:0] lpi_refresh_cycles = 16'h0040;
    localparam logic [7:0] crpat_long_len  = 8'hc0;
    localparam logic [7:0] crpat_short_len = 8'h20;
    typedef enum logic [1:0] {lpi_active, lpi_sleep, lpi_quiet, lpi_refresh} lpi_state_t;
endpackage

// ===== rtl/pcs_sigdet_lpi_fx_aux.sv
/*
 * Auxiliary control and status of the physical coding sublayer: signal
 * detect, transmit-to-receive loop, jitter patterns, low power idle and
 * fiber-mode supervision, with a classic Wishbone register slave.
 * Assumes all inputs are synchronous to core_clk and the coding core
 * supplies 10-bit code groups, sync status and low power indications.
 */
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module pcs_sigdet_lpi_fx_aux
    import pcs_aux_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        serdes_sigdet,
    input  wire logic        optic_sigdet_pin,
    input  wire logic [9:0]  tx_code_in,
    input  wire logic        mac_tx_lpi,
    input  wire logic [9:0]  serdes_rx_code,
    input  wire logic        rx_sync,
    input  wire logic        rx_lpi_symbol,
    input  wire logic        rx_lpi_quiet_in,
    input  wire logic        rx_far_fault,
    output logic [9:0]       serdes_tx_code,
    output logic [9:0]       rx_code_out,
    output logic             rx_sm_restart,
    output logic             rx_frame_enable,
    output logic             serdes_tx_halt,
    output logic             link_up,
    output logic             coding_4b5b
);
    logic [7:0]  sd_cfg;
    logic        tx_to_rx_loop_enable;
    logic [2:0]  jitter_pattern_select;
    logic        force_low_power_tx;
    logic [7:0]  fx_cfg;
    logic [15:0] wake_error_count;
    logic        rx_low_power_seen;
    logic        tx_low_power_seen;
    logic        far_fault_seen;
    logic        sync_lost_seen;
    logic        pat_error;
    logic        pat_lock;
    logic        rx_low_power_active;
    logic        rx_quiet;
    lpi_state_t  lpi_state;
    logic [15:0] lpi_timer;
    logic [7:0]  frame_cnt;
    logic [15:0] prbs;
    logic        sync_prev;
    logic        sigdet_now;
    logic        fx_sigdet_now;
    logic        sel_sigdet;
    logic        los_react;
    logic        one_way;
    logic        fx_mode;
    logic [9:0]  tx_code_prev;
    logic        bus_req;
    logic        bus_wr;
    logic        addr_ok;
    logic        w1c_rx;
    logic        w1c_tx;
    logic        w1c_fef;
    logic        w1c_sync;
    logic        tx_lpi_req;
    logic        tx_low_power_active;
    logic        tx_quiet;
    logic        sync_loss_evt;
    logic [9:0]  pattern_code;
    logic [9:0]  next_tx_code;
    logic [31:0] next_rdata;
    logic [15:0] next_lpi_timer;
    lpi_state_t  next_lpi_state;

    // Source then polarity; the pin is already synchronous here
    function automatic logic detect(input logic [7:0] cfg, input logic sd, input logic pin);
        logic raw;
        raw = cfg[sigdet_source_select_bit] ? pin : sd;
        return raw ^ cfg[sigdet_polarity_bit];
    endfunction

    function automatic logic w1c(input logic [31:0] d, input int bit_idx);
        return d[bit_idx];
    endfunction

    assign fx_mode       = fx_cfg[fx_ena_bit];
    assign sigdet_now    = detect(sd_cfg, serdes_sigdet, optic_sigdet_pin);
    assign fx_sigdet_now = detect(fx_cfg, serdes_sigdet, optic_sigdet_pin);
    assign sel_sigdet    = fx_mode ? fx_sigdet_now : sigdet_now;
    assign los_react     = fx_mode ? fx_cfg[los_react_enable_bit] : sd_cfg[los_react_enable_bit];
    assign one_way       = fx_mode & fx_cfg[unidir_bit];

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0] & addr_ok;
    assign w1c_rx   = bus_wr && wb_adr_i == lpi_stat_addr && w1c(wb_dat_i, rx_seen_bit);
    assign w1c_tx   = bus_wr && wb_adr_i == lpi_stat_addr && w1c(wb_dat_i, tx_seen_bit);
    assign w1c_fef  = bus_wr && wb_adr_i == fx_stat_addr && w1c(wb_dat_i, st_fef_bit);
    assign w1c_sync = bus_wr && wb_adr_i == fx_stat_addr && w1c(wb_dat_i, st_synclost_bit);

    // Gigabit registers vanish while fiber mode owns the port
    always_comb begin
        case (wb_adr_i)
            fx_cfg_addr, fx_stat_addr: addr_ok = 1'b1;
            sd_cfg_addr, lb_cfg_addr, tstpat_cfg_addr, tstpat_stat_addr,
            lpi_cfg_addr, lpi_stat_addr, wake_cnt_addr, link_stat_addr:
                addr_ok = ~fx_mode;
            default: addr_ok = 1'b0;
        endcase
    end

    assign tx_lpi_req          = (mac_tx_lpi | force_low_power_tx) & ~fx_mode;
    assign tx_low_power_active = lpi_state != lpi_active;
    assign tx_quiet            = lpi_state == lpi_quiet;
    assign sync_loss_evt       = fx_mode & sync_prev & ~rx_sync;

    always_comb begin
        next_lpi_state = lpi_state;
        next_lpi_timer = lpi_timer + 16'h0001;
        case (lpi_state)
            lpi_active: begin
                next_lpi_timer = 16'h0000;
                if (tx_lpi_req) begin
                    next_lpi_state = lpi_sleep;
                end
            end
            lpi_sleep: begin
                if (!tx_lpi_req) begin
                    next_lpi_state = lpi_active;
                    next_lpi_timer = 16'h0000;
                end else if (lpi_timer == lpi_sleep_cycles - 16'h0001) begin
                    next_lpi_state = lpi_quiet;
                    next_lpi_timer = 16'h0000;
                end
            end
            lpi_quiet: begin
                if (!tx_lpi_req) begin
                    next_lpi_state = lpi_active;
                    next_lpi_timer = 16'h0000;
                end else if (lpi_timer == lpi_quiet_cycles - 16'h0001) begin
                    next_lpi_state = lpi_refresh;
                    next_lpi_timer = 16'h0000;
                end
            end
            lpi_refresh: begin
                if (!tx_lpi_req) begin
                    next_lpi_state = lpi_active;
                    next_lpi_timer = 16'h0000;
                end else if (lpi_timer == lpi_refresh_cycles - 16'h0001) begin
                    next_lpi_state = lpi_quiet;
                    next_lpi_timer = 16'h0000;
                end
            end
            default: begin
                next_lpi_state = lpi_active;
                next_lpi_timer = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lpi_state <= lpi_active;
            lpi_timer <= 16'h0000;
        end else begin
            lpi_state <= next_lpi_state;
            lpi_timer <= next_lpi_timer;
        end
    end

    always_comb begin
        case (jitter_pattern_select)
            jtp_high:  pattern_code = hf_code;
            jtp_low:   pattern_code = lf_code;
            jtp_mixed: pattern_code = mf_code;
            jtp_crpat_long, jtp_crpat_short:
                pattern_code = (frame_cnt == 8'h00) ? k28_5_code : prbs[9:0];
            default:   pattern_code = idle_code;
        endcase
    end

    // Pattern generator overrides everything outside fiber mode; one-way keeps sending regardless
    always_comb begin
        if (jitter_pattern_select != jtp_off && !fx_mode) begin
            next_tx_code = pattern_code;
        end else if (tx_low_power_active) begin
            next_tx_code = lpi_code;
        end else if (fx_mode && fx_cfg[fef_gen_bit] && !rx_sync && !one_way) begin
            next_tx_code = fef_code;
        end else begin
            next_tx_code = tx_code_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            frame_cnt <= 8'h00;
            prbs      <= 16'h0001;
        end else if (jitter_pattern_select == jtp_crpat_long
                     || jitter_pattern_select == jtp_crpat_short) begin
            prbs <= {prbs[14:0], prbs[15] ^ prbs[13] ^ prbs[12] ^ prbs[10]};
            if (frame_cnt == ((jitter_pattern_select == jtp_crpat_long)
                              ? crpat_long_len : crpat_short_len)) begin
                frame_cnt <= 8'h00;
            end else begin
                frame_cnt <= frame_cnt + 8'h01;
            end
        end else begin
            frame_cnt <= 8'h00;
        end
    end

    // Checker: echo is held against last cycle's code, the loop's own lag
    always_ff @(posedge core_clk) begin
        if (rst || jitter_pattern_select == jtp_off) begin
            pat_error <= 1'b0;
            pat_lock  <= 1'b0;
        end else if (rx_code_out == tx_code_prev) begin
            pat_lock <= 1'b1;
        end else if (pat_lock) begin
            pat_error <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            serdes_tx_code  <= idle_code;
            rx_code_out     <= idle_code;
            tx_code_prev    <= idle_code;
            serdes_tx_halt  <= 1'b0;
            coding_4b5b     <= 1'b0;
        end else begin
            serdes_tx_code <= next_tx_code;
            rx_code_out    <= tx_to_rx_loop_enable ? serdes_tx_code : serdes_rx_code;
            tx_code_prev   <= serdes_tx_code;
            serdes_tx_halt <= (next_lpi_state == lpi_quiet);
            coding_4b5b    <= fx_mode;
        end
    end

    // Loss of signal only acts while reaction is enabled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_sm_restart   <= 1'b0;
            rx_frame_enable <= 1'b0;
            link_up         <= 1'b0;
        end else begin
            rx_sm_restart   <= los_react & ~sel_sigdet;
            rx_frame_enable <= ~(los_react & ~sel_sigdet) & rx_sync;
            link_up         <= rx_sync & ~(los_react & ~sel_sigdet);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_low_power_active <= 1'b0;
            rx_quiet            <= 1'b0;
            sync_prev           <= 1'b0;
        end else begin
            if (rx_lpi_symbol) begin
                rx_low_power_active <= 1'b1;
            end else if (!rx_lpi_quiet_in) begin
                rx_low_power_active <= 1'b0;
            end
            rx_quiet  <= rx_lpi_quiet_in & (rx_low_power_active | rx_lpi_symbol);
            sync_prev <= rx_sync;
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_low_power_seen <= 1'b0;
            tx_low_power_seen <= 1'b0;
            far_fault_seen    <= 1'b0;
            sync_lost_seen    <= 1'b0;
        end else begin
            rx_low_power_seen <= rx_lpi_symbol | (rx_low_power_seen & ~w1c_rx);
            tx_low_power_seen <= (serdes_tx_code == lpi_code)
                                 | (tx_low_power_seen & ~w1c_tx);
            far_fault_seen    <= (fx_mode & fx_cfg[fef_chk_bit] & rx_far_fault)
                                 | (far_fault_seen & ~w1c_fef);
            sync_lost_seen    <= sync_loss_evt | (sync_lost_seen & ~w1c_sync);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wake_error_count <= 16'h0000;
        end else if (!fx_mode && sel_sigdet && !rx_sync
                     && rx_low_power_active && wake_error_count != 16'hffff) begin
            wake_error_count <= wake_error_count + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sd_cfg                <= sd_cfg_reset;
            tx_to_rx_loop_enable  <= 1'b0;
            jitter_pattern_select <= jtp_off;
            force_low_power_tx    <= 1'b0;
            fx_cfg                <= fx_cfg_reset;
        end else if (bus_wr) begin
            case (wb_adr_i)
                sd_cfg_addr:     sd_cfg <= wb_dat_i[7:0];
                lb_cfg_addr:     tx_to_rx_loop_enable <= wb_dat_i[0];
                tstpat_cfg_addr: jitter_pattern_select <= wb_dat_i[2:0];
                lpi_cfg_addr:    force_low_power_tx <= wb_dat_i[0];
                fx_cfg_addr:     fx_cfg <= wb_dat_i[7:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            sd_cfg_addr:      next_rdata[7:0] = sd_cfg;
            lb_cfg_addr:      next_rdata[0] = tx_to_rx_loop_enable;
            tstpat_cfg_addr:  next_rdata[2:0] = jitter_pattern_select;
            tstpat_stat_addr: next_rdata[1:0] = {pat_lock, pat_error};
            lpi_cfg_addr:     next_rdata[0] = force_low_power_tx;
            lpi_stat_addr: begin
                next_rdata[rx_mode_bit]  = rx_low_power_active;
                next_rdata[rx_quiet_bit] = rx_quiet;
                next_rdata[tx_mode_bit]  = tx_low_power_active;
                next_rdata[tx_quiet_bit] = tx_quiet;
                next_rdata[rx_seen_bit]  = rx_low_power_seen;
                next_rdata[tx_seen_bit]  = tx_low_power_seen;
            end
            wake_cnt_addr:    next_rdata[15:0] = wake_error_count;
            link_stat_addr: begin
                next_rdata[st_sigdet_bit] = sigdet_now;
                next_rdata[st_sync_bit]   = rx_sync;
            end
            fx_cfg_addr:      next_rdata[7:0] = fx_cfg;
            fx_stat_addr: begin
                next_rdata[st_sigdet_bit]   = fx_sigdet_now;
                next_rdata[st_sync_bit]     = rx_sync;
                next_rdata[st_synclost_bit] = sync_lost_seen;
                next_rdata[st_fef_bit]      = far_fault_seen;
            end
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    // One wait state: ack or err one cycle after the request, then drops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req & addr_ok;
            wb_err_o <= bus_req & ~addr_ok;
            wb_dat_o <= (bus_req & addr_ok & ~wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end
endmodule

// ===== dv/pcs_aux_sva.sv
/* Port checker for the coding-sublayer auxiliary block.
   Assumes one clock, core_clk, and synchronous active-high rst. */
`timescale 1ns/10ps
module pcs_aux_sva
    import pcs_aux_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  wb_adr_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        rx_sync,
    input wire logic [9:0]  serdes_tx_code,
    input wire logic        rx_sm_restart,
    input wire logic        rx_frame_enable,
    input wire logic        link_up,
    input wire logic        coding_4b5b
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    bus_answer_a: assert property (req |=> wb_ack_o ^ wb_err_o)
        else $error("bus request left unanswered");
    answer_pulse_a: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
        else $error("bus answer longer than one cycle");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    unmapped_err_a: assert property (req && wb_adr_i > fx_stat_addr |=> wb_err_o)
        else $error("unmapped access not refused");
    fiber_mask_a: assert property (req && coding_4b5b && wb_adr_i < fx_cfg_addr |=> wb_err_o)
        else $error("gigabit register open in fiber mode");
    restart_stop_a: assert property (rx_sm_restart |-> !rx_frame_enable)
        else $error("frames accepted during restart");
    fiber_sync_a: assert property ((coding_4b5b && !rx_sync) [*2] |-> !link_up)
        else $error("link up without sync");
    reset_idle_a: assert property (disable iff (1'b0) rst |=> serdes_tx_code == idle_code && !link_up)
        else $error("outputs not idle after reset");
endmodule
bind pcs_sigdet_lpi_fx_aux pcs_aux_sva pcs_aux_sva_inst (.core_clk, .rst, .wb_adr_i,
    .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .rx_sync, .serdes_tx_code,
    .rx_sm_restart, .rx_frame_enable, .link_up, .coding_4b5b);

// ===== dv/link_partner_model.sv
/* Serial link partner: echoes the transmit stream one cycle late.
   Assumes the bench steers sync and idle requests. */
`timescale 1ns/10ps
module link_partner_model
    import pcs_aux_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic [9:0] serdes_tx_code,
    input  wire logic       serdes_tx_halt,
    input  wire logic       sync_ok,
    input  wire logic       lpi_req,
    output logic [9:0]      serdes_rx_code,
    output logic            rx_sync,
    output logic            rx_lpi_symbol,
    output logic            rx_lpi_quiet_in,
    output logic            rx_far_fault
);
    logic [9:0] last_code;
    initial begin
        last_code = idle_code;
        serdes_rx_code = idle_code;
        {rx_sync, rx_lpi_symbol, rx_lpi_quiet_in, rx_far_fault} = 4'h0;
    end
    always @(posedge core_clk) begin
        // Halted line must not look like live data
        last_code <= serdes_tx_halt ? last_code : serdes_tx_code;
        serdes_rx_code <= serdes_tx_halt ? ~last_code : serdes_tx_code;
        rx_sync <= sync_ok;
        rx_lpi_symbol <= lpi_req;
        rx_lpi_quiet_in <= lpi_req && serdes_tx_halt;
        rx_far_fault <= serdes_tx_code == fef_code;
    end
endmodule

// ===== dv/testbench.sv
/* Self-checking bench for the auxiliary block.
   Assumes the partner model on the serial side. */
`timescale 1ns/10ps
module testbench
    import pcs_aux_pkg::*;
;
    logic        core_clk = 0, rst = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = 4'hf;
    logic        wb_ack_o, wb_err_o, er, serdes_sigdet = 0, optic_sigdet_pin = 0;
    logic        mac_tx_lpi = 0, sync_ok = 1, lpi_req = 0, rx_sync, rx_lpi_symbol;
    logic        rx_lpi_quiet_in, rx_far_fault, rx_sm_restart, rx_frame_enable;
    logic        serdes_tx_halt, link_up, coding_4b5b;
    logic [9:0]  tx_code_in = 10'h283, serdes_rx_code, serdes_tx_code, rx_code_out;
    logic [9:0]  q[$];
    int          miscompares = 0, compares = 0, cycles = 0;
    pcs_sigdet_lpi_fx_aux pcs_sigdet_lpi_fx_aux_inst (.core_clk, .rst, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
        .serdes_sigdet, .optic_sigdet_pin, .tx_code_in, .mac_tx_lpi, .serdes_rx_code,
        .rx_sync, .rx_lpi_symbol, .rx_lpi_quiet_in, .rx_far_fault, .serdes_tx_code,
        .rx_code_out, .rx_sm_restart, .rx_frame_enable, .serdes_tx_halt, .link_up,
        .coding_4b5b);
    link_partner_model link_partner_model_inst (.core_clk, .serdes_tx_code,
        .serdes_tx_halt, .sync_ok, .lpi_req, .serdes_rx_code, .rx_sync,
        .rx_lpi_symbol, .rx_lpi_quiet_in, .rx_far_fault);
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic report_and_stop;
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        // Whole run needs under 4000 cycles
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        wb_we_i <= 0;
    endtask
    function automatic logic sel_det(input int i);
        return i[2] ? optic_sigdet_pin : serdes_sigdet;
    endfunction
    initial begin
        void'($urandom(48183));
        repeat (5) @(posedge core_clk);
        rst <= 0;
        bus(0, sd_cfg_addr, 0);
        check(rd, {24'h0, sd_cfg_reset});
        bus(0, fx_cfg_addr, 0);
        check(rd, {24'h0, fx_cfg_reset});
        bus(0, 8'h30, 0);
        check(er, 1);
        for (int i = 0; i < 8; i++) begin
            serdes_sigdet <= 1'($urandom);
            optic_sigdet_pin <= 1'($urandom);
            bus(1, sd_cfg_addr, 32'(i));
            repeat (3) @(posedge core_clk);
            bus(0, link_stat_addr, 0);
            check(rd[st_sigdet_bit], sel_det(i) ^ i[1]);
            check(rx_sm_restart, i[0] & ~(sel_det(i) ^ i[1]));
        end
        bus(1, sd_cfg_addr, 0);
        bus(1, lb_cfg_addr, 1);
        repeat (24) begin
            @(posedge core_clk);
            tx_code_in <= 10'($urandom);
            q.push_back(tx_code_in);
            if (q.size() > 2) check(rx_code_out, q.pop_front());
            if (q.size() > 1) check(serdes_tx_code, q[0]);
        end
        @(posedge core_clk);
        tx_code_in <= idle_code;
        for (int j = 1; j < 6; j++) begin
            bus(1, tstpat_cfg_addr, 32'(j));
            repeat (3) @(posedge core_clk);
            if (j < 4) check(serdes_tx_code, j == 1 ? hf_code : j == 2 ? lf_code : mf_code);
            if (j == 1) begin
                bus(0, tstpat_stat_addr, 0);
                check(rd[pat_lock_bit:pat_err_bit], 2'b10);
            end
        end
        bus(1, tstpat_cfg_addr, 0);
        bus(1, lb_cfg_addr, 0);
        bus(1, lpi_cfg_addr, 1);
        repeat (100) @(posedge core_clk);
        bus(0, lpi_stat_addr, 0);
        check(rd[5:2], 4'hf & 4'b1011 | 4'h2);
        check(serdes_tx_halt, 1);
        repeat (2030) @(posedge core_clk);
        bus(0, lpi_stat_addr, 0);
        check(rd[tx_quiet_bit:tx_mode_bit], 2'b01);
        lpi_req <= 1;
        bus(0, lpi_stat_addr, 0);
        bus(0, lpi_stat_addr, 0);
        check(rd[rx_seen_bit], 1);
        check(rd[rx_quiet_bit:rx_mode_bit], 2'b01);
        serdes_sigdet <= 1;
        sync_ok <= 0;
        // Ten cycles unsynced while detecting in low power
        repeat (10) @(posedge core_clk);
        sync_ok <= 1;
        bus(0, wake_cnt_addr, 0);
        check(rd[15:0], 16'h000a);
        lpi_req <= 0;
        bus(1, lpi_cfg_addr, 0);
        repeat (10) @(posedge core_clk);
        bus(1, lpi_stat_addr, 32'h30);
        bus(0, lpi_stat_addr, 0);
        check(rd[5:4], 0);
        bus(1, fx_cfg_addr, 32'h70);
        repeat (2) @(posedge core_clk);
        check(coding_4b5b, 1);
        bus(0, sd_cfg_addr, 0);
        check(er, 1);
        sync_ok <= 0;
        repeat (4) @(posedge core_clk);
        check(link_up, 0);
        check(serdes_tx_code, fef_code);
        bus(0, fx_stat_addr, 0);
        check(rd[st_synclost_bit], 1);
        check(rd[st_fef_bit], 1);
        check(rd[st_sigdet_bit], 1);
        bus(1, fx_cfg_addr, 32'hf0);
        repeat (2) @(posedge core_clk);
        check(serdes_tx_code, idle_code);
        sync_ok <= 1;
        repeat (4) @(posedge core_clk);
        bus(1, fx_stat_addr, 32'hc);
        bus(0, fx_stat_addr, 0);
        check(rd[st_fef_bit:st_synclost_bit], 2'b00);
        report_and_stop();
    end
endmodule
